// ---- rtl/scc_pkg.sv ----
// How it works
// - A rising edge on conversion_start switches every channel's sample-and-hold to hold and starts a conversion.
// - The conversion is a sixteen-step binary search from half scale down to one part in 65536, one bit per step.
// - At the end of the search the sixteen-bit code is assembled and handed to the serial output side, or dropped if the last is still pending.
// - The selected full-scale range is split into two to the sixteenth levels, so every result has sixteen bits.
// - Range codes 7, 6, 3 and 2 are bipolar and give a two's complement result.
// - Range codes 5, 4, 1 and 0 are unipolar and give a straight binary result.
// - Channel and range are taken afresh for every conversion, so each one may differ from the last.
// - A programmed list of channel and range pairs may instead be stepped through on successive conversions.
// - With the nominal reference, range 7 spans plus or minus 10.24 V, so one code step is 312.5 uV.
// - All channels track during acquisition, so a new selection needs no extra settling before it converts.
// - Optional nap and power-down states may be used between conversions, and no input is sampled in them.
// - A static pin level chooses between the single-ended and the differential result port.
package scc_pkg;

  localparam int unsigned RESULT_BITS    = 16;
  localparam int unsigned CHAN_COUNT     = 8;
  localparam int unsigned SEQ_DEPTH      = 8;

  // Comparator settle time per search step, including the two-stage synchroniser
  localparam int unsigned COMP_SETTLE_NS = 300;
  localparam int unsigned REF_CLK_MHZ    = 10;
  localparam int unsigned SETTLE_CYC     = (COMP_SETTLE_NS * REF_CLK_MHZ + 999) / 1000;

  // One code step on the widest bipolar range, in tenths of a microvolt
  localparam int unsigned LSB_R7_UV_X10  = 3125;
  localparam logic [2:0]  RANGE_PM_WIDE  = 3'h7;

  localparam logic [15:0] DAC_RESET      = 16'h0000;
  localparam logic [2:0]  SEQ_IDX_RESET  = 3'h0;

  typedef struct packed {
    logic [2:0] channel;
    logic [2:0] range;
  } scc_select_t;

  typedef struct packed {
    logic [2:0]  channel;
    logic [2:0]  range;
    logic [15:0] code;
  } scc_result_t;

  typedef enum logic [2:0] {
    SCC_TRACK,
    SCC_CONVERT,
    SCC_FINISH,
    SCC_NAP,
    SCC_POWER_DOWN
  } scc_state_t;

endpackage

// ---- rtl/scc_conversion_control.sv ----
`timescale 1ns/10ps
module scc_conversion_control
  import scc_pkg::*;
(
  // Core clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  // Host pins
  input  wire logic        conversion_start,
  input  wire logic [2:0]  pin_channel,
  input  wire logic [2:0]  pin_range,
  input  wire logic        seq_mode,
  input  wire logic        nap_req,
  input  wire logic        power_down_req,
  input  wire logic        lvds_select,
  // Sequence programming, core clock domain
  input  wire logic        seq_wr,
  input  wire logic [2:0]  seq_wr_idx,
  input  wire scc_select_t seq_wr_entry,
  input  wire logic [2:0]  seq_last_idx,
  // Analog front end
  input  wire logic        comparator_high,
  output logic             hold_all,
  output logic [15:0]      capacitor_search_dac,
  output logic [2:0]       mux_channel,
  output logic [2:0]       mux_range,
  // Status
  output logic             busy,
  output logic             nap_active,
  output logic             power_down_active,
  output logic             lvds_mode,
  output logic             result_dropped,
  // Serial port side, link clock domain
  input  wire logic        link_clk,
  output scc_result_t      link_result,
  output logic             link_result_strobe
);

  localparam int CONV_CYC  = RESULT_BITS * SETTLE_CYC;
  localparam int CONV_TAIL = CONV_CYC - 7;

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic is_bipolar(input logic [2:0] rng);
    is_bipolar = rng[1];
  endfunction

  function automatic logic [15:0] format_code(input logic [15:0] raw, input logic [2:0] rng);
    // Offset binary search word becomes two's complement by flipping the sign bit
    format_code = is_bipolar(rng) ? {~raw[15], raw[14:0]} : raw;
  endfunction

  // ****************************************
  // Pin synchronisers
  // ****************************************
  logic [1:0] start_sync_q;
  logic       start_prev_q;
  logic [1:0] comp_sync_q;
  logic [1:0] nap_sync_q;
  logic [1:0] pd_sync_q;
  logic [1:0] seqm_sync_q;
  logic [1:0] lvds_sync_q;
  logic [5:0] sel_meta_q;
  logic [5:0] sel_sync_q;
  logic [1:0] ack_sync_q;
  logic       link_ack_tgl_q, link_ack_tgl_d;

  always_ff @(posedge ref_clk)
  begin
    start_sync_q <= {start_sync_q[0], conversion_start};
    start_prev_q <= start_sync_q[1];
    comp_sync_q  <= {comp_sync_q[0], comparator_high};
    nap_sync_q   <= {nap_sync_q[0], nap_req};
    pd_sync_q    <= {pd_sync_q[0], power_down_req};
    seqm_sync_q  <= {seqm_sync_q[0], seq_mode};
    lvds_sync_q  <= {lvds_sync_q[0], lvds_select};
    sel_meta_q   <= {pin_channel, pin_range};
    sel_sync_q   <= sel_meta_q;
  end

  logic start_edge;
  assign start_edge = start_sync_q[1] & ~start_prev_q;

  // ****************************************
  // Sequence table
  // ****************************************
  scc_select_t seq_table_q [SEQ_DEPTH];

  always_ff @(posedge ref_clk)
  begin
    if (seq_wr)
    begin
      seq_table_q[seq_wr_idx] <= seq_wr_entry;
    end
  end

  // ****************************************
  // Conversion sequencer
  // ****************************************
  scc_state_t  state_q, state_d;
  scc_select_t sel_q, sel_d;
  logic [15:0] dac_q, dac_d;
  logic [3:0]  bit_q, bit_d;
  logic [3:0]  cnt_q, cnt_d;
  logic [2:0]  seq_idx_q, seq_idx_d;
  scc_result_t held_q, held_d;
  logic        req_tgl_q, req_tgl_d;
  logic        dropped_q, dropped_d;
  logic        lvds_q, lvds_d;
  logic        pending;

  assign pending = req_tgl_q ^ ack_sync_q[1];

  always_comb
  begin
    state_d   = state_q;
    sel_d     = sel_q;
    dac_d     = dac_q;
    bit_d     = bit_q;
    cnt_d     = cnt_q;
    seq_idx_d = seq_idx_q;
    held_d    = held_q;
    req_tgl_d = req_tgl_q;
    dropped_d = 1'b0;
    lvds_d    = lvds_sync_q[1];
    case (state_q)
      SCC_TRACK:
      begin
        if (pd_sync_q[1])
        begin
          state_d = SCC_POWER_DOWN;
        end
        else if (nap_sync_q[1])
        begin
          state_d = SCC_NAP;
        end
        else if (start_edge)
        begin
          state_d = SCC_CONVERT;
          if (seqm_sync_q[1])
          begin
            sel_d     = seq_table_q[seq_idx_q];
            seq_idx_d = (seq_idx_q >= seq_last_idx) ? SEQ_IDX_RESET : 3'(seq_idx_q + 3'h1);
          end
          else
          begin
            sel_d     = scc_select_t'(sel_sync_q);
            seq_idx_d = SEQ_IDX_RESET;
          end
          dac_d = 16'h8000;
          bit_d = 4'(RESULT_BITS - 1);
          cnt_d = 4'h0;
        end
      end
      SCC_CONVERT:
      begin
        // Start edges are not looked at here
        if (cnt_q == 4'(SETTLE_CYC - 1))
        begin
          cnt_d        = 4'h0;
          dac_d[bit_q] = comp_sync_q[1];
          if (bit_q == 4'h0)
          begin
            state_d = SCC_FINISH;
          end
          else
          begin
            bit_d                      = 4'(bit_q - 4'h1);
            dac_d[4'(bit_q - 4'h1)]    = 1'b1;
          end
        end
        else
        begin
          cnt_d = 4'(cnt_q + 4'h1);
        end
      end
      SCC_FINISH:
      begin
        state_d = SCC_TRACK;
        // The link side may be stalled; a result it has not taken yet is kept, the new one is lost
        if (pending)
        begin
          dropped_d = 1'b1;
        end
        else
        begin
          held_d    = '{channel: sel_q.channel, range: sel_q.range,
                        code: format_code(dac_q, sel_q.range)};
          req_tgl_d = ~req_tgl_q;
        end
      end
      SCC_NAP:
      begin
        if (!nap_sync_q[1])
        begin
          state_d = SCC_TRACK;
        end
      end
      SCC_POWER_DOWN:
      begin
        if (!pd_sync_q[1])
        begin
          state_d = SCC_TRACK;
        end
      end
      default:
      begin
        state_d = SCC_TRACK;
      end
    endcase
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      state_q    <= SCC_TRACK;
      sel_q      <= '0;
      dac_q      <= DAC_RESET;
      bit_q      <= 4'h0;
      cnt_q      <= 4'h0;
      seq_idx_q  <= SEQ_IDX_RESET;
      held_q     <= '0;
      req_tgl_q  <= 1'b0;
      dropped_q  <= 1'b0;
      lvds_q     <= 1'b0;
      ack_sync_q <= 2'b00;
    end
    else
    begin
      state_q    <= state_d;
      sel_q      <= sel_d;
      dac_q      <= dac_d;
      bit_q      <= bit_d;
      cnt_q      <= cnt_d;
      seq_idx_q  <= seq_idx_d;
      held_q     <= held_d;
      req_tgl_q  <= req_tgl_d;
      dropped_q  <= dropped_d;
      lvds_q     <= lvds_d;
      ack_sync_q <= {ack_sync_q[0], link_ack_tgl_q};
    end
  end

  // All channels track outside conversion; the mux only routes the converting one
  assign hold_all             = (state_q == SCC_CONVERT);
  assign capacitor_search_dac = dac_q;
  assign mux_channel          = sel_q.channel;
  assign mux_range            = sel_q.range;
  assign busy                 = (state_q == SCC_CONVERT) || (state_q == SCC_FINISH);
  assign nap_active           = (state_q == SCC_NAP);
  assign power_down_active    = (state_q == SCC_POWER_DOWN);
  assign lvds_mode            = lvds_q;
  assign result_dropped       = dropped_q;

  // ****************************************
  // Link side, toggle handshake
  // ****************************************
  logic [1:0]  link_rst_sync_q;
  logic [1:0]  link_req_sync_q;
  logic        link_seen_q, link_seen_d;
  scc_result_t link_word_q, link_word_d;
  logic        link_stb_q, link_stb_d;

  always_comb
  begin
    link_seen_d    = link_req_sync_q[1];
    link_ack_tgl_d = link_ack_tgl_q;
    link_word_d    = link_word_q;
    link_stb_d     = 1'b0;
    // Held word is stable in the core domain until the ack returns
    if (link_req_sync_q[1] != link_seen_q)
    begin
      link_word_d    = held_q;
      link_stb_d     = 1'b1;
      link_ack_tgl_d = ~link_ack_tgl_q;
    end
  end

  always_ff @(posedge link_clk)
  begin
    link_rst_sync_q <= {link_rst_sync_q[0], rst_n};
    if (!link_rst_sync_q[1])
    begin
      link_req_sync_q <= 2'b00;
      link_seen_q     <= 1'b0;
      link_ack_tgl_q  <= 1'b0;
      link_word_q     <= '0;
      link_stb_q      <= 1'b0;
    end
    else
    begin
      link_req_sync_q <= {link_req_sync_q[0], req_tgl_q};
      link_seen_q     <= link_seen_d;
      link_ack_tgl_q  <= link_ack_tgl_d;
      link_word_q     <= link_word_d;
      link_stb_q      <= link_stb_d;
    end
  end

  assign link_result        = link_word_q;
  assign link_result_strobe = link_stb_q;

  // ****************************************
  // Checks
  // ****************************************
  a_start_holds: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (state_q == SCC_TRACK && !pd_sync_q[1] && !nap_sync_q[1] && start_edge) |=> hold_all && dac_q == 16'h8000)
    else $error("start edge did not begin a held conversion");

  a_search_length: assert property (@(posedge ref_clk) disable iff (!rst_n)
    $rose(hold_all) |-> hold_all [*8] ##[CONV_TAIL:CONV_TAIL] (state_q == SCC_FINISH))
    else $error("binary search length wrong");

  a_step_halves: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (state_q == SCC_CONVERT && cnt_q == 4'(SETTLE_CYC - 1) && bit_q != 4'h0)
      |=> dac_q[bit_q] == 1'b1 && dac_q[$past(bit_q)] == $past(comp_sync_q[1]))
    else $error("search step did not decide bit and try next");

  a_bipolar_code: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (state_q == SCC_FINISH && !pending && is_bipolar(sel_q.range))
      |=> held_q.code == {~$past(dac_q[15]), $past(dac_q[14:0])})
    else $error("bipolar result not two's complement");

  a_unipolar_code: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (state_q == SCC_FINISH && !pending && !is_bipolar(sel_q.range)) |=> held_q.code == $past(dac_q))
    else $error("unipolar result not straight binary");

  a_result_handed: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (state_q == SCC_FINISH && !pending) |=> pending && held_q.channel == $past(sel_q.channel))
    else $error("finished code not handed to output side");

  a_edge_ignored: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (state_q == SCC_CONVERT) |=> $stable(sel_q) && (state_q != SCC_TRACK))
    else $error("selection changed during conversion");

  a_pin_select: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (state_q == SCC_TRACK && start_edge && !seqm_sync_q[1] && !pd_sync_q[1] && !nap_sync_q[1])
      |=> sel_q == scc_select_t'($past(sel_sync_q)))
    else $error("per-conversion selection not taken");

  a_seq_advance: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (state_q == SCC_TRACK && start_edge && seqm_sync_q[1] && !pd_sync_q[1] && !nap_sync_q[1])
      |=> sel_q == $past(seq_table_q[seq_idx_q]) && seq_idx_q != $past(seq_idx_q) || seq_last_idx == 3'h0)
    else $error("sequence entry not used or not advanced");

  a_idle_no_sample: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (nap_active || power_down_active) |-> !hold_all ##1 !hold_all)
    else $error("input sampled during nap or power-down");

  a_port_select: assert property (@(posedge ref_clk) disable iff (!rst_n)
    1'b1 |=> lvds_mode == $past(lvds_sync_q[1]))
    else $error("port variant does not follow select pin");

endmodule

// ---- dv/scc_afe_model.sv ----
`timescale 1ns/10ps
module scc_afe_model
(
  // Core clock
  input  wire logic             ref_clk,
  // Channel inputs, offset-binary levels
  input  wire logic [7:0][15:0] level,
  // Front end control from the block
  input  wire logic             hold_all,
  input  wire logic [15:0]      capacitor_search_dac,
  input  wire logic [2:0]       mux_channel,
  output logic                  comparator_high
);
  // ***************************************
  // Sample and hold of every channel
  // ***************************************
  logic [7:0][15:0] held_q;

  // All channels track while hold is low, so a new selection needs no settling
  always_ff @(posedge ref_clk)
  begin
    if (!hold_all)
      held_q <= level;
  end

  // Trial at or below the held level keeps the bit
  assign comparator_high = (capacitor_search_dac <= held_q[mux_channel]);
endmodule

// ---- dv/sar_conversion_control_tb.sv ----
`timescale 1ns/10ps
module sar_conversion_control_tb;
  import scc_pkg::*;
  // ***************************************
  // Signals
  // ***************************************
  logic             ref_clk, link_clk, rst_n, conversion_start, seq_mode, nap_req;
  logic             power_down_req, lvds_select, seq_wr, comparator_high, hold_all;
  logic             busy, nap_active, power_down_active, lvds_mode, result_dropped, link_result_strobe;
  logic [2:0]       pin_channel, pin_range, seq_wr_idx, seq_last_idx, mux_channel, mux_range;
  logic [15:0]      capacitor_search_dac;
  logic [7:0][15:0] lvl;
  scc_select_t      seq_wr_entry;
  scc_result_t      link_result;
  int               fails, total_checks, cyc;
  bit               link_run;

  scc_conversion_control i_scc_conversion_control (.ref_clk(ref_clk), .rst_n(rst_n),
    .conversion_start(conversion_start), .pin_channel(pin_channel), .pin_range(pin_range),
    .seq_mode(seq_mode), .nap_req(nap_req), .power_down_req(power_down_req), .lvds_select(lvds_select),
    .seq_wr(seq_wr), .seq_wr_idx(seq_wr_idx), .seq_wr_entry(seq_wr_entry), .seq_last_idx(seq_last_idx),
    .comparator_high(comparator_high), .hold_all(hold_all), .capacitor_search_dac(capacitor_search_dac),
    .mux_channel(mux_channel), .mux_range(mux_range), .busy(busy), .nap_active(nap_active),
    .power_down_active(power_down_active), .lvds_mode(lvds_mode), .result_dropped(result_dropped),
    .link_clk(link_clk), .link_result(link_result), .link_result_strobe(link_result_strobe));

  scc_afe_model i_scc_afe_model (.ref_clk(ref_clk), .level(lvl), .hold_all(hold_all),
    .capacitor_search_dac(capacitor_search_dac), .mux_channel(mux_channel),
    .comparator_high(comparator_high));

  // ***************************************
  // Clocks, timeout and checking helpers
  // ***************************************
  initial
  begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end

  // Link clock deliberately offset so its edges drift against the core clock
  initial
  begin
    link_clk = 1'b0;
    #7;
    forever #15 link_clk = link_run ? ~link_clk : link_clk;
  end

  always @(posedge ref_clk)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      fails++;
      $display("Error at %0t: timeout", $time);
      stop_test();
    end
  end

  task automatic stop_test();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic chk_res(input scc_result_t got, input scc_result_t exp);
    total_checks++;
    if (got !== exp)
    begin
      fails++;
      $display("Error at %0t: result %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_bit(input logic got, input logic exp);
    total_checks++;
    if (got !== exp)
    begin
      fails++;
      $display("Error at %0t: flag %b expected %b", $time, got, exp);
    end
  endtask

  task automatic chk_num(input int got, input int exp);
    total_checks++;
    if (got != exp)
    begin
      fails++;
      $display("Error at %0t: count %0d expected %0d", $time, got, exp);
    end
  endtask

  // One conversion; in sequence mode the pins carry a wrong selection on purpose
  task automatic conv(input logic [2:0] ch, input logic [2:0] rg, input bit dbl);
    int          n;
    logic [15:0] lv;
    @(posedge ref_clk);
    pin_channel <= seq_mode ? ~ch : ch;
    pin_range   <= seq_mode ? ~rg : rg;
    repeat (3) @(posedge ref_clk);
    conversion_start <= 1'b1;
    n = 0;
    while (hold_all !== 1'b1 && n < 10)
    begin
      @(negedge ref_clk);
      n++;
    end
    chk_bit(busy, 1'b1);
    chk_res(scc_result_t'({mux_channel, mux_range, capacitor_search_dac}), scc_result_t'({ch, rg, 16'h8000}));
    lv      = lvl[ch];
    lvl[ch] = ~lv;
    n       = 0;
    while (hold_all === 1'b1 && n < 100)
    begin
      @(negedge ref_clk);
      n++;
      if (n == 2 || (dbl && (n == 6 || n == 10)))
      begin
        @(posedge ref_clk);
        conversion_start <= (dbl && n == 6);
      end
    end
    chk_num(n, 48);
    lvl[ch] = lv;
    n       = 0;
    while (link_result_strobe !== 1'b1 && n < 50)
    begin
      @(negedge link_clk);
      n++;
    end
    chk_res(link_result, scc_result_t'({ch, rg, rg[1] ? {~lv[15], lv[14:0]} : lv}));
    repeat (12) @(negedge ref_clk);
    chk_bit(hold_all, 1'b0);
  endtask

  // ***************************************
  // Scenarios
  // ***************************************
  task automatic test_ranges();
    for (int r = 0; r < 8; r++)
      conv(3'(7 - r), 3'(r), 1'b0);
    $display("test_ranges done");
  endtask

  task automatic test_seq();
    for (int i = 0; i < 3; i++)
    begin
      @(posedge ref_clk);
      seq_wr       <= 1'b1;
      seq_wr_idx   <= 3'(i);
      seq_wr_entry <= '{channel: 3'(i + 4), range: 3'(6 - 2 * i)};
    end
    @(posedge ref_clk);
    seq_wr       <= 1'b0;
    seq_last_idx <= 3'h2;
    seq_mode     <= 1'b1;
    for (int i = 0; i < 4; i++)
      conv(3'(i % 3 + 4), 3'(6 - 2 * (i % 3)), 1'b0);
    @(posedge ref_clk);
    seq_mode <= 1'b0;
    $display("test_seq done");
  endtask

  task automatic test_restart();
    conv(3'h3, 3'h7, 1'b1);
    $display("test_restart done");
  endtask

  task automatic test_low_power();
    @(posedge ref_clk);
    nap_req     <= 1'b1;
    lvds_select <= 1'b1;
    repeat (5) @(negedge ref_clk);
    chk_bit(nap_active, 1'b1);
    chk_bit(lvds_mode, 1'b1);
    @(posedge ref_clk);
    conversion_start <= 1'b1;
    repeat (3) @(posedge ref_clk);
    conversion_start <= 1'b0;
    repeat (8) @(negedge ref_clk);
    chk_bit(hold_all, 1'b0);
    @(posedge ref_clk);
    nap_req        <= 1'b0;
    power_down_req <= 1'b1;
    repeat (6) @(negedge ref_clk);
    chk_bit(power_down_active, 1'b1);
    chk_bit(nap_active, 1'b0);
    @(posedge ref_clk);
    power_down_req <= 1'b0;
    lvds_select    <= 1'b0;
    repeat (5) @(negedge ref_clk);
    chk_bit(power_down_active, 1'b0);
    chk_bit(lvds_mode, 1'b0);
    conv(3'h6, 3'h1, 1'b0);
    $display("test_low_power done");
  endtask

  // Stalled link: the first result is kept, the second is dropped and flagged
  task automatic test_dropped();
    int   n;
    logic seen;
    link_run = 1'b0;
    for (int k = 0; k < 2; k++)
    begin
      @(posedge ref_clk);
      pin_channel <= 3'(k + 1);
      pin_range   <= 3'h5;
      repeat (3) @(posedge ref_clk);
      conversion_start <= 1'b1;
      repeat (4) @(posedge ref_clk);
      conversion_start <= 1'b0;
      seen = 1'b0;
      for (n = 0; n < 70; n++)
      begin
        @(negedge ref_clk);
        seen = seen | (result_dropped === 1'b1);
      end
      chk_bit(seen, 1'(k));
    end
    link_run = 1'b1;
    n        = 0;
    while (link_result_strobe !== 1'b1 && n < 50)
    begin
      @(negedge link_clk);
      n++;
    end
    chk_res(link_result, scc_result_t'({3'h1, 3'h5, lvl[1]}));
    $display("test_dropped done");
  endtask

  // ***************************************
  // Main sequence
  // ***************************************
  initial
  begin
    rst_n            = 1'b0;
    conversion_start = 1'b0;
    {seq_mode, nap_req, power_down_req, lvds_select, seq_wr} = 5'h00;
    {pin_channel, pin_range, seq_wr_idx, seq_last_idx} = 12'h000;
    seq_wr_entry     = '0;
    lvl              = {16'h0001, 16'hedcb, 16'h1234, 16'h7fff, 16'h0000, 16'hffff, 16'h8001, 16'h8000};
    fails            = 0;
    total_checks     = 0;
    cyc              = 0;
    link_run         = 1'b1;
    repeat (4) @(posedge ref_clk);
    rst_n <= 1'b1;
    test_ranges();
    test_seq();
    test_restart();
    test_low_power();
    test_dropped();
    stop_test();
  end
endmodule
